// File: sim/fifo_rt_assertions.sv
// checker on the pins between the fifo and its controller
// assumes one clock; tb_top wires it beside fifo_link_if
`timescale 1ns/100ps
module fifo_rt_assertions (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // controller pins
    input wire logic master_reset_n,
    input wire logic write_en_n,
    input wire logic read_en_n,
    input wire logic load_n,
    input wire logic retransmit_n,
    input wire logic retransmit_latency_select,
    input wire logic flag_timing_select,
    input wire logic first_word_fall_through,
    // fifo pins
    input wire logic empty_flag_n,
    input wire logic out_ready_flag_n,
    input wire logic almost_full_flag_n,
    input wire logic almost_empty_flag_n
);
    logic sync_reg;
    logic normal_reg;
    logic ft_reg;
    // other events that move flags
    wire evt = !master_reset_n || !load_n || !retransmit_n;
    wire rt_go = !retransmit_n && master_reset_n;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // straps as the fifo takes them
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sync_reg <= 1'b1;
            normal_reg <= 1'b1;
            ft_reg <= 1'b0;
        end else if (!master_reset_n) begin
            sync_reg <= flag_timing_select;
            normal_reg <= retransmit_latency_select;
            ft_reg <= first_word_fall_through;
        end
    end
    af_sync_set_a: assert property (sync_reg && $fell(almost_full_flag_n) |->
        !$past(write_en_n, 2) || $past(evt) || $past(evt, 2))
        else $error("sync af set, no write");
    af_sync_clr_a: assert property (sync_reg && $rose(almost_full_flag_n) |->
        !$past(read_en_n, 2) || $past(evt) || $past(evt, 2))
        else $error("sync af clear, no read");
    ae_sync_set_a: assert property (sync_reg && $fell(almost_empty_flag_n) |->
        !$past(read_en_n, 2) || $past(evt) || $past(evt, 2))
        else $error("sync ae set, no read");
    ae_sync_clr_a: assert property (sync_reg && $rose(almost_empty_flag_n) |->
        !$past(write_en_n, 2) || $past(evt) || $past(evt, 2))
        else $error("sync ae clear, no write");
    af_async_set_a: assert property (!sync_reg && $fell(almost_full_flag_n) |->
        !$past(write_en_n) || $past(evt))
        else $error("async af set, no write");
    ae_async_clr_a: assert property (!sync_reg && $rose(almost_empty_flag_n) |->
        !$past(write_en_n) || $past(evt))
        else $error("async ae clear, no write");
    rt_zero_std_a: assert property (!normal_reg && !ft_reg && rt_go |=> empty_flag_n)
        else $error("zero replay empty low");
    rt_zero_ft_a: assert property (!normal_reg && ft_reg && rt_go |=> !out_ready_flag_n)
        else $error("zero replay ready high");
    rt_normal_std_a: assert property (normal_reg && !ft_reg && rt_go |=>
        (!empty_flag_n) [*2] ##[1:3] empty_flag_n)
        else $error("normal replay timing");
    rt_normal_ft_a: assert property (normal_reg && ft_reg && rt_go |=>
        out_ready_flag_n [*2] ##[1:3] !out_ready_flag_n)
        else $error("ft replay timing");
endmodule

// File: sim/tb_top.sv
// bench: fifo and controller on fifo_link_if, via the register port
// assumes design files, package and constants header are compiled before it
`timescale 1ns/100ps
`include "fifo_rt_defines.svh"
module tb_top
    import fifo_rt_pkg::*;
;
    typedef struct {
        logic [2:0] cfg;
        int n;
        int pre;
        logic pae_n;
    } row_t;
    row_t rows[7] = '{'{3'h6, 3, 1, 1'b0}, '{3'h7, 5, 1, 1'b0}, '{3'h0, 2, 2, 1'b0},
        '{3'h1, 4, 4, 1'b0}, '{3'h4, 128, 1, 1'b1}, '{3'h3, 200, 1, 1'b1},
        '{3'h2, 127, 1, 1'b0}};
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [`RA_W-1:0] reg_addr = '0;
    logic [`DW-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [`DW-1:0] reg_rdata;
    logic [`DW-1:0] rv;
    ptr_t fill_level;
    logic rt_busy;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    int zl;

    fifo_link_if fifo_link_if_i (.clk_sys(clk_sys), .rst(rst));
    fifo_rt_device fifo_rt_device_i (.clk_sys(clk_sys), .rst(rst), .lnk(fifo_link_if_i),
        .fill_level(fill_level), .rt_busy(rt_busy));
    fifo_rt_host fifo_rt_host_i (.clk_sys(clk_sys), .rst(rst), .lnk(fifo_link_if_i),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    fifo_rt_assertions fifo_rt_assertions_i (.clk_sys(clk_sys), .rst(rst),
        .master_reset_n(fifo_link_if_i.master_reset_n),
        .write_en_n(fifo_link_if_i.write_en_n), .read_en_n(fifo_link_if_i.read_en_n),
        .load_n(fifo_link_if_i.load_n), .retransmit_n(fifo_link_if_i.retransmit_n),
        .retransmit_latency_select(fifo_link_if_i.retransmit_latency_select),
        .flag_timing_select(fifo_link_if_i.flag_timing_select),
        .first_word_fall_through(fifo_link_if_i.first_word_fall_through),
        .empty_flag_n(fifo_link_if_i.empty_flag_n),
        .out_ready_flag_n(fifo_link_if_i.out_ready_flag_n),
        .almost_full_flag_n(fifo_link_if_i.almost_full_flag_n),
        .almost_empty_flag_n(fifo_link_if_i.almost_empty_flag_n));

    initial begin
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic chk(input string what, input logic [`DW-1:0] seen,
        input logic [`DW-1:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic idle(input int c);
        repeat (c) @(posedge clk_sys);
    endtask
    task automatic wr(input logic [`RA_W-1:0] a, input logic [`DW-1:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [`RA_W-1:0] a, output logic [`DW-1:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic pop(output logic [`DW-1:0] d);
        wr(`RA_RDATA, '0);
        idle(3);
        rd(`RA_RDATA, d);
    endtask
    task automatic rb(input logic [`DW-1:0] exp);
        wr(`RA_CTRL, 36'h10);
        idle(3);
        chk("offset readback", fifo_link_if_i.dout, exp);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // a hang counts as a mismatch
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            err_total++;
            complete_run();
        end
    end

    initial begin
        idle(16);
        rst <= 1'b0;
        foreach (rows[k]) begin
            wr(`RA_CFG, 36'(rows[k].cfg));
            wr(`RA_CTRL, 36'h1);
            idle(4);
            for (int i = 0; i < rows[k].n; i++) wr(`RA_WDATA, 36'h100 + 36'(i));
            idle(4);
            rd(`RA_CTRL, rv);
            chk("almost empty", 36'(rv[3]), 36'(rows[k].pae_n));
            for (int i = 0; i < rows[k].pre; i++) pop(rv);
            chk("word before replay", rv, 36'h100 + 36'(rows[k].pre - 1));
            wr(`RA_CTRL, 36'h4);
            idle(8);
            zl = rows[k].cfg[1:0] == 2'h0;
            chk("fill after replay", 36'(fill_level), 36'(rows[k].n - zl));
            if (zl != 0) chk("head at once", fifo_link_if_i.dout, 36'h100);
            for (int i = zl; i < rows[k].n; i++) begin
                pop(rv);
                chk("replayed word", rv, 36'h100 + 36'(i));
            end
        end
        // capacity one word larger in fall-through
        for (int f = 0; f < 2; f++) begin
            wr(`RA_CFG, 36'h6 + 36'(f));
            wr(`RA_CTRL, 36'h21);
            idle(4);
            for (int i = 0; i < 1023 + f; i++) wr(`RA_WDATA, 36'(i));
            idle(3);
            chk("not yet full", 36'(fifo_link_if_i.full_flag_n), 36'h1);
            wr(`RA_WDATA, 36'h0);
            idle(3);
            chk("full", 36'(fifo_link_if_i.full_flag_n), 36'h0);
        end
        wr(`RA_CTRL, 36'h4);
        rd(`RA_CTRL, rv);
        chk("full replay refused", 36'(rv[0]), 36'h1);
        wr(`RA_CTRL, 36'h21);
        wr(`RA_WDATA, 36'h5);
        wr(`RA_CTRL, 36'h4);
        rd(`RA_CTRL, rv);
        chk("replay of one word refused", 36'(rv[0]), 36'h1);
        wr(`RA_CFG, 36'h6);
        wr(`RA_CTRL, 36'h21);
        wr(`RA_SER, 36'h2B4A5);
        wr(`RA_CTRL, 36'h8);
        idle(`SER_W + 6);
        rb(36'h0A5);
        rb(36'h15A);
        wr(`RA_OFS, 36'h2);
        wr(`RA_OFS, 36'h1FF);
        rb(36'h2);
        rb(36'h1FF);
        wr(`RA_WDATA, 36'h1);
        wr(`RA_WDATA, 36'h2);
        idle(3);
        chk("almost empty at offset", 36'(fifo_link_if_i.almost_empty_flag_n), 36'h0);
        wr(`RA_WDATA, 36'h3);
        idle(3);
        chk("almost empty above", 36'(fifo_link_if_i.almost_empty_flag_n), 36'h1);
        for (int i = 3; i < 512; i++) wr(`RA_WDATA, 36'(i));
        idle(3);
        chk("almost full below", 36'(fifo_link_if_i.almost_full_flag_n), 36'h1);
        wr(`RA_WDATA, 36'h0);
        idle(3);
        chk("almost full at", 36'(fifo_link_if_i.almost_full_flag_n), 36'h0);
        pop(rv);
        chk("almost full after read", 36'(fifo_link_if_i.almost_full_flag_n), 36'h1);
        // mid-run reset
        rst <= 1'b1;
        idle(2);
        chk("pins in reset", {fill_level, fifo_link_if_i.empty_flag_n, fifo_link_if_i.full_flag_n,
            fifo_link_if_i.almost_empty_flag_n, fifo_link_if_i.almost_full_flag_n}, 36'h5);
        rst <= 1'b0;
        idle(2);
        rb(36'h07F);
        complete_run();
    end
endmodule

// File: verilog/fifo_link_if.sv
// pins between the fifo and its controller
// assumes both ends on clk_sys; active-low pins end in _n
`timescale 1ns/100ps
`include "fifo_rt_defines.svh"
interface fifo_link_if (
    input wire logic clk_sys,
    input wire logic rst
);
    logic master_reset_n;
    logic partial_reset_n;
    logic write_en_n;
    logic read_en_n;
    logic load_n;
    logic output_en_n;
    logic retransmit_n;
    logic serial_en_n;
    logic serial_in;
    logic retransmit_latency_select;
    logic flag_timing_select;
    logic first_word_fall_through;
    logic [`DW-1:0] din;
    logic [`DW-1:0] dout;
    logic dout_oe;
    logic full_flag_n;
    logic input_ready_flag_n;
    logic empty_flag_n;
    logic out_ready_flag_n;
    logic almost_full_flag_n;
    logic almost_empty_flag_n;

    modport dev (
        input clk_sys, rst, master_reset_n, partial_reset_n, write_en_n, read_en_n,
        input load_n, output_en_n, retransmit_n, serial_en_n, serial_in,
        input retransmit_latency_select, flag_timing_select, first_word_fall_through, din,
        output dout, dout_oe, full_flag_n, input_ready_flag_n, empty_flag_n,
        output out_ready_flag_n, almost_full_flag_n, almost_empty_flag_n
    );
    modport host (
        input clk_sys, rst, dout, dout_oe, full_flag_n, input_ready_flag_n, empty_flag_n,
        input out_ready_flag_n, almost_full_flag_n, almost_empty_flag_n,
        output master_reset_n, partial_reset_n, write_en_n, read_en_n, load_n,
        output output_en_n, retransmit_n, serial_en_n, serial_in,
        output retransmit_latency_select, flag_timing_select, first_word_fall_through, din
    );
endinterface

// File: verilog/fifo_rt_defines.svh
// constants of the retransmit fifo and its controller
// assumes one clock for both ends and a 36-bit word
`ifndef FIFO_RT_DEFINES_SVH
`define FIFO_RT_DEFINES_SVH
`define DW 36
`define AW 10
`define PW 11
`define MEM_WORDS 1024
`define DEPTH_STD 11'h400
`define DEPTH_FT 11'h401
`define OFS_W 9
`define OFS_DEF 9'h07F
`define SER_W 18
`define SER_LEN 5'h12
`define RT_LAT 2'h2
`define RT_GUARD 2'h3
`define RT_MIN_WORDS 11'h002
`define RT_MAX_STD 11'h3FE
`define RT_MAX_FT 11'h3FF
`define RA_W 5
`define RA_CTRL 5'h00
`define RA_CFG 5'h04
`define RA_WDATA 5'h08
`define RA_RDATA 5'h0C
`define RA_OFS 5'h10
`define RA_SER 5'h14
`define CB_MST 0
`define CB_PRS 1
`define CB_RT 2
`define CB_SER 3
`define CB_RDBK 4
`define CB_CLR 5
`define GB_FT 0
`define GB_RTSEL 1
`define GB_SYNC 2
`define CFG_W 3
`define CFG_DEF 3'h6
`endif

// File: verilog/fifo_rt_device.sv
// fifo end: storage, retransmit, offset registers and almost flags
// assumes the controller on fifo_link_if shares clk_sys and rst
//
// Behaviour
// RL1: two words stored before replay
// RL2: at most depth minus two before replay
// RL3: fall-through holds one extra word
// RL4: fall-through normal replay ends at ready low
// RL5: latency select high: normal replay
// RL6: latency select low: zero latency
// RL7: zero latency standard: data at once
// RL8: zero latency fall-through: data at once
// RL9: serial offsets nine bits each
// RL10: parallel offset load from data input
// RL11: parallel offset readback on data output
// RL12: sync almost-full moves on write edges
// RL13: timing select high: synchronous flags
// RL14: timing select low: asynchronous flags
// RL15: async almost-full: set write, clear read
// RL16: async almost-empty: set read, clear write
// RL17: sync almost-full clears cycle after read
// RL18: sync almost-empty clears cycle after write
// RL19: sync almost-empty moves on read edges
// RL20: replay rewinds read pointer, not write
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "fifo_rt_defines.svh"
module fifo_rt_device
    import fifo_rt_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // pins to the controller
    fifo_link_if.dev lnk,
    // local status
    output ptr_t fill_level,
    output logic rt_busy
);
    logic ft_reg;
    logic rt_normal_reg;
    logic flag_sync_reg;
    ptr_t wr_ptr_reg;
    ptr_t rd_ptr_reg;
    ptr_t rd_ptr_next;
    logic out_valid_reg;
    logic out_valid_next;
    word_t dout_reg;
    word_t dout_next;
    logic [1:0] busy_reg;
    ofs_t ae_ofs_reg;
    ofs_t af_ofs_reg;
    logic ofs_sel_reg;
    logic af_sync_reg;
    logic ae_sync_reg;
    word_t mem_q;
    ptr_t mem_cnt;
    ptr_t total_cnt;
    ptr_t capacity;
    logic [`AW-1:0] rd_addr;

    wire normal_op = lnk.master_reset_n && lnk.partial_reset_n;
    wire ctl_reset = !normal_op;
    wire ld_mode = !lnk.load_n;
    wire busy = busy_reg != 2'h0;
    wire mem_empty = mem_cnt == '0;

    assign mem_cnt = wr_ptr_reg - rd_ptr_reg;
    assign total_cnt = mem_cnt + ptr_t'(out_valid_reg);
    // RL3: extra output word
    assign capacity = ft_reg ? `DEPTH_FT : `DEPTH_STD;

    // second term guards memory while the output word is moving
    wire is_full = (total_cnt == capacity) || (mem_cnt == `DEPTH_STD);
    wire wr_go = normal_op && !lnk.write_en_n && !ld_mode && !is_full;
    wire rt_go = normal_op && !lnk.retransmit_n;
    // RL5 RL6: mode split
    wire rt_zero = rt_go && !rt_normal_reg;
    wire rt_norm = rt_go && rt_normal_reg;
    wire rd_req = normal_op && !lnk.read_en_n && !ld_mode;
    wire std_pop = !ft_reg && rd_req && !mem_empty && !busy && !rt_go;
    wire ft_take = ft_reg && rd_req && out_valid_reg;
    wire ft_fill = ft_reg && !mem_empty && (!out_valid_reg || ft_take) && !busy && !rt_go;
    wire pop = std_pop || ft_fill;
    wire ofs_wr = normal_op && ld_mode && !lnk.write_en_n;
    wire ofs_rd = normal_op && ld_mode && !lnk.read_en_n;
    wire ser_shift = normal_op && !ld_mode && !lnk.serial_en_n;

    // RL7 RL8: zero latency fetches word one now
    assign rd_addr = rt_zero ? '0 : rd_ptr_reg[`AW-1:0];

    // RL20: rewind read side only
    assign rd_ptr_next = rt_zero ? ptr_t'(1'b1) :
                         rt_norm ? '0 :
                         pop ? rd_ptr_reg + ptr_t'(1'b1) : rd_ptr_reg;

    assign out_valid_next = rt_zero ? ft_reg :
                            rt_norm ? 1'b0 :
                            ft_fill ? 1'b1 :
                            ft_take ? 1'b0 : out_valid_reg;

    // RL11: readback in the low bits of the word
    assign dout_next = ofs_rd ? word_t'(ofs_sel_reg ? af_ofs_reg : ae_ofs_reg) :
                       (rt_zero || pop) ? mem_q : dout_reg;

    fifo_store u_store (
        .clk_sys(clk_sys),
        .wr_en(wr_go),
        .wr_addr(wr_ptr_reg[`AW-1:0]),
        .wr_data(lnk.din),
        .rd_addr(rd_addr),
        .rd_data(mem_q)
    );

    // RL5 RL6 RL13 RL14: straps caught while master reset is low
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ft_reg <= 1'b0;
            rt_normal_reg <= 1'b1;
            flag_sync_reg <= 1'b1;
        end else if (!lnk.master_reset_n) begin
            ft_reg <= lnk.first_word_fall_through;
            rt_normal_reg <= lnk.retransmit_latency_select;
            flag_sync_reg <= lnk.flag_timing_select;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= '0;
        end else if (ctl_reset) begin
            wr_ptr_reg <= '0;
        end else if (wr_go) begin
            wr_ptr_reg <= wr_ptr_reg + ptr_t'(1'b1);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_ptr_reg <= '0;
            out_valid_reg <= 1'b0;
            dout_reg <= '0;
        end else if (ctl_reset) begin
            rd_ptr_reg <= '0;
            out_valid_reg <= 1'b0;
            dout_reg <= '0;
        end else begin
            rd_ptr_reg <= rd_ptr_next;
            out_valid_reg <= out_valid_next;
            dout_reg <= dout_next;
        end
    end

    // RL4: normal replay stalls reads for setup
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy_reg <= 2'h0;
        end else if (ctl_reset) begin
            busy_reg <= 2'h0;
        end else if (rt_norm) begin
            busy_reg <= `RT_LAT;
        end else if (busy) begin
            busy_reg <= busy_reg - 2'h1;
        end
    end

    // partial reset keeps offsets; master reset restores defaults
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ae_ofs_reg <= `OFS_DEF;
            af_ofs_reg <= `OFS_DEF;
        end else if (!lnk.master_reset_n) begin
            ae_ofs_reg <= `OFS_DEF;
            af_ofs_reg <= `OFS_DEF;
        end else if (ofs_wr) begin
            // RL10: parallel load alternates empty then full offset
            if (ofs_sel_reg) begin
                af_ofs_reg <= lnk.din[`OFS_W-1:0];
            end else begin
                ae_ofs_reg <= lnk.din[`OFS_W-1:0];
            end
        end else if (ser_shift) begin
            // RL9: nine bits each, lsb first, empty offset first
            {af_ofs_reg, ae_ofs_reg} <= {lnk.serial_in, af_ofs_reg, ae_ofs_reg[`OFS_W-1:1]};
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ofs_sel_reg <= 1'b0;
        end else if (ctl_reset) begin
            ofs_sel_reg <= 1'b0;
        end else if (ofs_wr || ofs_rd) begin
            ofs_sel_reg <= !ofs_sel_reg;
        end
    end

    wire af_cond = total_cnt >= (capacity - ptr_t'(af_ofs_reg));
    wire ae_cond = total_cnt <= ptr_t'(ae_ofs_reg);

    // RL12 RL17 RL18 RL19: sync flags lag the count one edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            af_sync_reg <= 1'b0;
            ae_sync_reg <= 1'b1;
        end else if (ctl_reset) begin
            af_sync_reg <= 1'b0;
            ae_sync_reg <= 1'b1;
        end else begin
            af_sync_reg <= af_cond;
            ae_sync_reg <= ae_cond;
        end
    end

    // RL15 RL16: async flags follow the count at once
    assign lnk.almost_full_flag_n = !(flag_sync_reg ? af_sync_reg : af_cond);
    assign lnk.almost_empty_flag_n = !(flag_sync_reg ? ae_sync_reg : ae_cond);
    assign lnk.full_flag_n = !is_full;
    assign lnk.input_ready_flag_n = is_full;
    // RL5: standard empty flag held low during normal replay setup
    assign lnk.empty_flag_n = !(mem_empty || busy);
    // RL4 RL8: ready flag low once the head word is loaded
    assign lnk.out_ready_flag_n = !out_valid_reg;
    assign lnk.dout = dout_reg;
    assign lnk.dout_oe = !lnk.output_en_n;
    assign fill_level = total_cnt;
    assign rt_busy = busy;
endmodule

// File: verilog/fifo_rt_host.sv
// controller end: register port for software, drives the fifo pins
// assumes the fifo on fifo_link_if shares clk_sys and rst
`timescale 1ns/100ps
`include "fifo_rt_defines.svh"
module fifo_rt_host
    import fifo_rt_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // pins to the fifo
    fifo_link_if.host lnk,
    // software register port
    input wire logic [`RA_W-1:0] reg_addr,
    input wire logic [`DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`DW-1:0] reg_rdata
);
    logic [`CFG_W-1:0] cfg_reg;
    logic mst_n_reg, prs_n_reg, wen_n_reg, ren_n_reg, ld_n_reg, rt_n_reg;
    logic sen_n_reg, si_reg, rd_cap_reg, refused_reg;
    word_t din_reg, rdbuf_reg, rdata_reg;
    logic [`SER_W-1:0] ser_reg;
    logic [4:0] ser_cnt_reg;
    ser_state_t ser_state_reg;
    logic [1:0] rt_wait_reg;
    ptr_t wr_count_reg;

    wire ft = cfg_reg[`GB_FT];
    wire wr_ctrl = reg_wr && reg_addr == `RA_CTRL;
    wire wr_cfg = reg_wr && reg_addr == `RA_CFG;
    wire wr_data = reg_wr && reg_addr == `RA_WDATA;
    wire wr_pop = reg_wr && reg_addr == `RA_RDATA;
    wire wr_ofs = reg_wr && reg_addr == `RA_OFS;
    wire wr_ser = reg_wr && reg_addr == `RA_SER;
    wire ser_idle = ser_state_reg == SER_IDLE;
    wire room = ft ? !lnk.input_ready_flag_n : lnk.full_flag_n;
    wire avail = ft ? !lnk.out_ready_flag_n : lnk.empty_flag_n;
    wire do_reset = wr_ctrl && (reg_wdata[`CB_MST] || reg_wdata[`CB_PRS]);
    wire push_ok = wr_data && room;
    // RL4: no reads until setup has finished
    wire pop_ok = wr_pop && avail && rt_wait_reg == 2'h0;
    // RL1 RL2: replay needs a legal word count
    wire rt_cnt_ok = wr_count_reg >= `RT_MIN_WORDS &&
                     wr_count_reg <= (ft ? `RT_MAX_FT : `RT_MAX_STD);
    wire rt_req = wr_ctrl && reg_wdata[`CB_RT];
    wire rt_ok = rt_req && rt_cnt_ok;
    wire rdbk_ok = wr_ctrl && reg_wdata[`CB_RDBK];
    wire refuse = (wr_data && !room) || (wr_pop && !pop_ok) || (rt_req && !rt_cnt_ok);
    // fall-through word already on the pins
    wire cap_now = !ren_n_reg && ld_n_reg && ft;
    wire flag_done = ft ? !lnk.out_ready_flag_n : lnk.empty_flag_n;

    // RL5 RL6 RL13 RL14: straps from configuration
    assign lnk.first_word_fall_through = cfg_reg[`GB_FT];
    assign lnk.retransmit_latency_select = cfg_reg[`GB_RTSEL];
    assign lnk.flag_timing_select = cfg_reg[`GB_SYNC];
    assign lnk.master_reset_n = mst_n_reg;
    assign lnk.partial_reset_n = prs_n_reg;
    assign lnk.write_en_n = wen_n_reg;
    assign lnk.read_en_n = ren_n_reg;
    assign lnk.load_n = ld_n_reg;
    assign lnk.retransmit_n = rt_n_reg;
    assign lnk.serial_en_n = sen_n_reg;
    assign lnk.serial_in = si_reg;
    assign lnk.din = din_reg;
    assign lnk.output_en_n = 1'b0;
    assign reg_rdata = rdata_reg;

    // one-cycle pin strobes, registered
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mst_n_reg <= 1'b1;
            prs_n_reg <= 1'b1;
            wen_n_reg <= 1'b1;
            ren_n_reg <= 1'b1;
            ld_n_reg <= 1'b1;
            rt_n_reg <= 1'b1;
            din_reg <= '0;
        end else begin
            mst_n_reg <= !(wr_ctrl && reg_wdata[`CB_MST]);
            prs_n_reg <= !(wr_ctrl && reg_wdata[`CB_PRS]);
            wen_n_reg <= !(push_ok || wr_ofs);
            ren_n_reg <= !(pop_ok || rdbk_ok);
            ld_n_reg <= !(wr_ofs || rdbk_ok);
            rt_n_reg <= !rt_ok;
            if (push_ok || wr_ofs) begin
                // RL10: offset word on the data input
                din_reg <= reg_wdata;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cfg_reg <= `CFG_DEF;
            wr_count_reg <= '0;
            rt_wait_reg <= 2'h0;
            refused_reg <= 1'b0;
        end else begin
            if (wr_cfg) begin
                cfg_reg <= reg_wdata[`CFG_W-1:0];
            end
            if (do_reset) begin
                wr_count_reg <= '0;
            end else if (push_ok && wr_count_reg != `DEPTH_FT) begin
                wr_count_reg <= wr_count_reg + ptr_t'(1'b1);
            end
            // RL4: guard spans the pin delay
            if (do_reset) begin
                rt_wait_reg <= 2'h0;
            end else if (rt_ok && cfg_reg[`GB_RTSEL]) begin
                rt_wait_reg <= `RT_GUARD;
            end else if (rt_wait_reg > 2'h1 || (rt_wait_reg == 2'h1 && flag_done)) begin
                rt_wait_reg <= rt_wait_reg - 2'h1;
            end
            // set wins over clear
            if (refuse) begin
                refused_reg <= 1'b1;
            end else if (wr_ctrl && reg_wdata[`CB_CLR]) begin
                refused_reg <= 1'b0;
            end
        end
    end

    // RL11: readback lands a cycle after the strobe
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_cap_reg <= 1'b0;
            rdbuf_reg <= '0;
        end else begin
            rd_cap_reg <= !ren_n_reg && !cap_now;
            if (cap_now || rd_cap_reg) begin
                rdbuf_reg <= lnk.dout;
            end
        end
    end

    // RL9: 18 bits, empty offset first, lsb first
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ser_state_reg <= SER_IDLE;
            ser_reg <= '0;
            ser_cnt_reg <= 5'h00;
            sen_n_reg <= 1'b1;
            si_reg <= 1'b0;
        end else begin
            unique case (ser_state_reg)
                SER_IDLE: begin
                    sen_n_reg <= 1'b1;
                    if (wr_ser) begin
                        ser_reg <= reg_wdata[`SER_W-1:0];
                    end
                    if (wr_ctrl && reg_wdata[`CB_SER]) begin
                        ser_cnt_reg <= `SER_LEN;
                        ser_state_reg <= SER_SHIFT;
                    end
                end
                SER_SHIFT: begin
                    sen_n_reg <= 1'b0;
                    si_reg <= ser_reg[0];
                    ser_reg <= {1'b0, ser_reg[`SER_W-1:1]};
                    ser_cnt_reg <= ser_cnt_reg - 5'h01;
                    if (ser_cnt_reg == 5'h01) begin
                        ser_state_reg <= SER_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_reg <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `RA_CTRL: rdata_reg <= word_t'({lnk.full_flag_n, lnk.empty_flag_n,
                    lnk.input_ready_flag_n, lnk.out_ready_flag_n, lnk.almost_full_flag_n,
                    lnk.almost_empty_flag_n, rt_wait_reg != 2'h0, !ser_idle, refused_reg});
                `RA_CFG: rdata_reg <= word_t'(cfg_reg);
                `RA_RDATA: rdata_reg <= rdbuf_reg;
                `RA_SER: rdata_reg <= word_t'(ser_reg);
                default: rdata_reg <= '0;
            endcase
        end
    end
endmodule

// File: verilog/fifo_rt_pkg.sv
// shared types of the retransmit fifo and its controller
// assumes the constants header sits beside it
`include "fifo_rt_defines.svh"
package fifo_rt_pkg;
    typedef logic [`DW-1:0] word_t;
    typedef logic [`PW-1:0] ptr_t;
    typedef logic [`OFS_W-1:0] ofs_t;
    typedef enum {SER_IDLE, SER_SHIFT} ser_state_t;
endpackage

// File: verilog/fifo_store.sv
// word storage of the fifo, flip-flops addressed by index
// assumes the caller never writes and reads one slot for the same word
`timescale 1ns/100ps
`include "fifo_rt_defines.svh"
module fifo_store
    import fifo_rt_pkg::*;
(
    // clock
    input wire logic clk_sys,
    // write side
    input wire logic wr_en,
    input wire logic [`AW-1:0] wr_addr,
    input wire word_t wr_data,
    // read side
    input wire logic [`AW-1:0] rd_addr,
    output word_t rd_data
);
    word_t mem [0:`MEM_WORDS-1];

    // no reset: contents are don't-care until written
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    assign rd_data = mem[rd_addr];
endmodule
